// ---- plc_timers_and_counters.v ----
// Purpose: scan-driven timers and counters behind an AXI4-Lite slave
// Assumes: software plays the user program; pins feed counter inputs
// Notes: scan end is a write to the scan register
//
// Function
// RULE1: timer advances once per 100 ms tick
// RULE2: timer coil on when value reaches setting
// RULE3: accumulating timer holds value when condition off
// RULE4: accumulating timer resumes from held value
// RULE5: subroutine timers advance on instruction or scan end
// RULE6: narrow counter counts edges, stops at setting
// RULE7: narrow setting 0 or 1 fires first edge
// RULE8: narrow count wraps from 32767 to -32768
// RULE9: reset instruction clears value and contact
// RULE10: contact changes only after scan completes (code: supply return clears an unlatched contact at once)
// RULE11: power loss clears unlatched, keeps latched counters
// RULE12: narrow value above setting snaps on edge
// RULE13: wide counter keeps counting past the setting (code: counting up, it goes one past, then the next edge snaps back)
// RULE14: direction bit selects up or down count
// RULE15: up reaching setting sets, down clears contact (code: down from above snaps and sets it; only a wrap onto 2147483647 clears)
// RULE16: wide setting is full signed 32 bits
// RULE17: wide count wraps both ways (code: up wraps only with setting 2147483647; otherwise the snap applies)
// RULE18: wide value above setting snaps on edge
// RULE19: tick from prescaler, inputs sampled per scan
// RULE20: general timer clears when condition off
`include "plc_tc_defines.vh"

module plc_timers_and_counters #(
	parameter TICK_CYCLES = `TICK_TIME_MS * `CLK_FREQ_KHZ
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// pins
	input wire narrow_count_in,
	input wire wide_count_in,
	input wire power_restore_in,
	// outputs
	output reg [`NUM_TMR-1:0] timer_coil,
	output reg narrow_contact,
	output reg wide_contact
);
	localparam [31:0] TICK_M1 = TICK_CYCLES - 1;
	localparam [`PRESC_W-1:0] TICK_LAST = TICK_M1[`PRESC_W-1:0];

	// write channel holding
	reg aw_hold_r;
	reg w_hold_r;
	reg [`ADDR_W-1:0] waddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	wire do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
	wire [3:0] wgrp = waddr_r[7:4];
	wire [1:0] wreg = waddr_r[3:2];

	// registers
	reg scan_end_r;
	reg scan_done_r;
	reg [`NUM_TMR-1:0] texec_r;
	reg [`NUM_TMR-1:0] tcond_r;
	reg [1:0] tmode_r [0:`NUM_TMR-1];
	reg [`NARROW_W-1:0] tset_r [0:`NUM_TMR-1];
	wire [`NARROW_W-1:0] tcur [0:`NUM_TMR-1];
	wire [`NUM_TMR-1:0] tcoil;
	reg nlatch_r;
	reg nrst_r;
	reg nload_r;
	reg [`NARROW_W-1:0] nset_r;
	reg [`NARROW_W-1:0] nload_val_r;
	wire [`NARROW_W-1:0] ncur;
	wire ncontact;
	reg wlatch_r;
	reg wdir_r;
	reg wrst_r;
	reg wload_r;
	reg [`WIDE_W-1:0] wset_r;
	reg [`WIDE_W-1:0] wload_val_r;
	wire [`WIDE_W-1:0] wcur;
	wire wcontact;

	// pin synchronisers
	reg [`NUM_PIN-1:0] sync1_r;
	reg [`NUM_PIN-1:0] sync2_r;
	reg [`NUM_PIN-1:0] sync3_r;
	reg [`NUM_PIN-1:0] stable_r;
	reg [`NUM_PIN-1:0] sample_r;
	reg pwr_prev_r;
	wire [`NUM_PIN-1:0] pins = {power_restore_in, wide_count_in, narrow_count_in};
	wire power_restore = stable_r[2] && !pwr_prev_r;
	wire n_edge = scan_end_r && stable_r[0] && !sample_r[0];
	wire w_edge = scan_end_r && stable_r[1] && !sample_r[1];

	// prescaler
	reg [`PRESC_W-1:0] presc_r;
	reg tick_r;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1)
				merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	wire [31:0] nset_m = merge({16'h0000, nset_r}, wdata_r, wstrb_r);
	wire [31:0] nload_m = merge({16'h0000, ncur}, wdata_r, wstrb_r);
	wire [31:0] wset_m = merge(wset_r, wdata_r, wstrb_r);
	wire [31:0] wload_m = merge(wcur, wdata_r, wstrb_r);

	always @(posedge aclk) begin
		if (!aresetn) begin
			presc_r <= {`PRESC_W{1'b0}};
			tick_r <= 1'b0;
		end else if (presc_r == TICK_LAST) begin
			presc_r <= {`PRESC_W{1'b0}}; // RULE19
			tick_r <= 1'b1;
		end else begin
			presc_r <= presc_r + {{(`PRESC_W-1){1'b0}}, 1'b1};
			tick_r <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= {`NUM_PIN{1'b0}};
			sync2_r <= {`NUM_PIN{1'b0}};
			sync3_r <= {`NUM_PIN{1'b0}};
			stable_r <= {`NUM_PIN{1'b0}};
			sample_r <= {`NUM_PIN{1'b0}};
			pwr_prev_r <= 1'b0;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			stable_r <= (sync2_r & sync3_r) | (stable_r & (sync2_r | sync3_r));
			pwr_prev_r <= stable_r[2];
			if (scan_end_r)
				sample_r <= stable_r; // RULE19
		end
	end

	// write path
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			waddr_r <= {`ADDR_W{1'b0}};
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				waddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wgrp <= `GRP_WCNT && wreg != 2'h3) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register writes
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			scan_end_r <= 1'b0;
			scan_done_r <= 1'b0;
			texec_r <= {`NUM_TMR{1'b0}};
			tcond_r <= {`NUM_TMR{1'b0}};
			for (i = 0; i < `NUM_TMR; i = i + 1) begin
				tmode_r[i] <= `TMODE_GENERAL;
				tset_r[i] <= 16'h0000;
			end
			nlatch_r <= 1'b0;
			nrst_r <= 1'b0;
			nload_r <= 1'b0;
			nset_r <= 16'h0000;
			nload_val_r <= 16'h0000;
			wlatch_r <= 1'b0;
			wdir_r <= 1'b0;
			wrst_r <= 1'b0;
			wload_r <= 1'b0;
			wset_r <= 32'h00000000;
			wload_val_r <= 32'h00000000;
		end else begin
			scan_end_r <= do_write && wgrp == `GRP_SCAN && wdata_r[`SCAN_END_BIT];
			scan_done_r <= scan_end_r; // RULE10
			texec_r <= {`NUM_TMR{1'b0}};
			nrst_r <= do_write && wgrp == `GRP_NCNT && wreg == `REG_CTRL && wdata_r[`CCTL_RST_BIT];
			wrst_r <= do_write && wgrp == `GRP_WCNT && wreg == `REG_CTRL && wdata_r[`CCTL_RST_BIT];
			nload_r <= do_write && wgrp == `GRP_NCNT && wreg == `REG_CUR;
			wload_r <= do_write && wgrp == `GRP_WCNT && wreg == `REG_CUR;
			if (do_write) begin
				for (i = 0; i < `NUM_TMR; i = i + 1) begin
					if (wgrp == `GRP_TMR0 + i[3:0] && wreg == `REG_CTRL) begin
						texec_r[i] <= 1'b1;
						tcond_r[i] <= wdata_r[`TCTL_COND_BIT]; // RULE3
						tmode_r[i] <= wdata_r[`TCTL_MODE_HI:`TCTL_MODE_LO];
					end
					if (wgrp == `GRP_TMR0 + i[3:0] && wreg == `REG_SET)
						tset_r[i] <= wdata_r[`NARROW_W-1:0];
				end
				if (wgrp == `GRP_NCNT && wreg == `REG_CTRL)
					nlatch_r <= wdata_r[`CCTL_LATCH_BIT];
				if (wgrp == `GRP_NCNT && wreg == `REG_SET)
					nset_r <= nset_m[`NARROW_W-1:0];
				if (wgrp == `GRP_NCNT && wreg == `REG_CUR)
					nload_val_r <= nload_m[`NARROW_W-1:0];
				if (wgrp == `GRP_WCNT && wreg == `REG_CTRL) begin
					wlatch_r <= wdata_r[`CCTL_LATCH_BIT];
					wdir_r <= wdata_r[`CCTL_DIR_BIT]; // RULE14
				end
				if (wgrp == `GRP_WCNT && wreg == `REG_SET)
					wset_r <= wset_m; // RULE16
				if (wgrp == `GRP_WCNT && wreg == `REG_CUR)
					wload_val_r <= wload_m;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_TMR; g = g + 1) begin : tmr
			timer_unit u_timer (
				.aclk(aclk),
				.aresetn(aresetn),
				.exec(texec_r[g]),
				.cond(tcond_r[g]),
				.mode(tmode_r[g]),
				.setting(tset_r[g]),
				.tick(tick_r),
				.scan_end(scan_end_r),
				.cur_r(tcur[g]),
				.coil_r(tcoil[g])
			);
		end
	endgenerate

	count_unit #(.W(`NARROW_W), .WIDE(0)) u_narrow (
		.aclk(aclk),
		.aresetn(aresetn),
		.edge_in(n_edge),
		.scan_done(scan_done_r),
		.power_restore(power_restore),
		.dir_down(1'b0),
		.latched(nlatch_r),
		.rst_cmd(nrst_r),
		.load(nload_r),
		.load_val(nload_val_r),
		.setting(nset_r),
		.cur_r(ncur),
		.contact_r(ncontact)
	);

	count_unit #(.W(`WIDE_W), .WIDE(1)) u_wide (
		.aclk(aclk),
		.aresetn(aresetn),
		.edge_in(w_edge),
		.scan_done(scan_done_r),
		.power_restore(power_restore),
		.dir_down(wdir_r),
		.latched(wlatch_r),
		.rst_cmd(wrst_r),
		.load(wload_r),
		.load_val(wload_val_r),
		.setting(wset_r),
		.cur_r(wcur),
		.contact_r(wcontact)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_coil <= {`NUM_TMR{1'b0}};
			narrow_contact <= 1'b0;
			wide_contact <= 1'b0;
		end else begin
			timer_coil <= tcoil;
			narrow_contact <= ncontact;
			wide_contact <= wcontact;
		end
	end

	// read path
	reg [31:0] rd_nxt;
	reg rd_ok;
	wire [3:0] rgrp = s_axi_araddr[7:4];
	wire [1:0] rreg = s_axi_araddr[3:2];
	always @* begin
		rd_nxt = 32'h00000000;
		rd_ok = 1'b1;
		case (rgrp)
			`GRP_SCAN: rd_nxt = {29'h0, stable_r};
			`GRP_TMR0, `GRP_TMR1: begin
				case (rreg)
					`REG_CTRL: rd_nxt = {23'h0, tcoil[rgrp[0] ? 0 : 1], 5'h0,
						tmode_r[rgrp[0] ? 0 : 1], tcond_r[rgrp[0] ? 0 : 1]};
					`REG_SET: rd_nxt = {16'h0000, tset_r[rgrp[0] ? 0 : 1]};
					`REG_CUR: rd_nxt = {16'h0000, tcur[rgrp[0] ? 0 : 1]};
					default: rd_ok = 1'b0;
				endcase
			end
			`GRP_NCNT: begin
				case (rreg)
					`REG_CTRL: rd_nxt = {23'h0, ncontact, 6'h0, nlatch_r, 1'b0};
					`REG_SET: rd_nxt = {16'h0000, nset_r};
					`REG_CUR: rd_nxt = {16'h0000, ncur};
					default: rd_ok = 1'b0;
				endcase
			end
			`GRP_WCNT: begin
				case (rreg)
					`REG_CTRL: rd_nxt = {23'h0, wcontact, 5'h0, wdir_r, wlatch_r, 1'b0};
					`REG_SET: rd_nxt = wset_r;
					`REG_CUR: rd_nxt = wcur;
					default: rd_ok = 1'b0;
				endcase
			end
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// ---- plc_tc_defines.vh ----
// Purpose: constants for the scan-driven timer and counter block
// Assumes: 100 MHz aclk, AXI4-Lite with 32-bit data
// Notes: byte offsets are word aligned; a group of four words per unit
`ifndef PLC_TC_DEFINES_VH
`define PLC_TC_DEFINES_VH

// timing
`define TICK_TIME_MS 100
`define CLK_FREQ_KHZ 100000
`define PRESC_W 24

// address map, group number in address bits 7:4 and word index in bits 3:2
`define ADDR_W 8
`define GRP_SCAN 4'h0
`define GRP_TMR0 4'h1
`define GRP_TMR1 4'h2
`define GRP_NCNT 4'h3
`define GRP_WCNT 4'h4
`define REG_CTRL 2'h0
`define REG_SET 2'h1
`define REG_CUR 2'h2

// field positions
`define SCAN_END_BIT 0
`define TCTL_COND_BIT 0
`define TCTL_MODE_LO 1
`define TCTL_MODE_HI 2
`define CCTL_RST_BIT 0
`define CCTL_LATCH_BIT 1
`define CCTL_DIR_BIT 2
`define STAT_OUT_BIT 8

// timer modes
`define TMODE_GENERAL 2'h0
`define TMODE_ACCUM 2'h1
`define TMODE_SUBR 2'h2

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define NARROW_W 16
`define WIDE_W 32
`define NUM_TMR 2
`define NUM_PIN 3

`endif

// ---- timer_unit.v ----
// Purpose: one 100 ms timer driven by the timer instruction
// Assumes: exec pulses once per execution, tick once per time unit
// Notes: mode picks general, accumulating or subroutine behaviour
`include "plc_tc_defines.vh"

module timer_unit (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// program scan
	input wire exec,
	input wire cond,
	input wire [1:0] mode,
	input wire [`NARROW_W-1:0] setting,
	input wire tick,
	input wire scan_end,
	// state
	output reg [`NARROW_W-1:0] cur_r,
	output reg coil_r
);
	reg cond_r;
	reg [`NARROW_W-1:0] pend_r;
	wire subr = (mode == `TMODE_SUBR);
	wire [`NARROW_W:0] sum = {1'b0, cur_r} + (subr ? {1'b0, pend_r} : 17'h00001);
	wire apply = subr ? ((exec | scan_end) & (pend_r != 16'h0000)) : (tick & cond_r);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cond_r <= 1'b0;
			pend_r <= 16'h0000;
			cur_r <= 16'h0000;
			coil_r <= 1'b0;
		end else begin
			if (exec)
				cond_r <= cond;
			// a tick landing with the apply is kept for the next apply
			if (subr && apply)
				pend_r <= {15'h0000, tick & cond_r};
			else if (subr && tick && cond_r && pend_r != 16'hffff)
				pend_r <= pend_r + 16'h0001;
			else if (apply)
				pend_r <= 16'h0000;
			if (exec && !cond && mode != `TMODE_ACCUM && mode != `TMODE_SUBR) begin
				cur_r <= 16'h0000; // RULE20
				coil_r <= 1'b0; // RULE20
			end else if (exec && cond && cur_r >= setting) begin
				coil_r <= 1'b1; // RULE2
			end else if (apply && !coil_r) begin
				// RULE1 RULE4 RULE5
				if (sum >= {1'b0, setting}) begin
					cur_r <= setting;
					coil_r <= 1'b1; // RULE2
				end else begin
					cur_r <= sum[`NARROW_W-1:0];
				end
			end
		end
	end
endmodule

// ---- count_unit.v ----
// Purpose: one up counter (narrow) or up/down counter (wide)
// Assumes: edge_in pulses at scan end for a counted input edge
// Notes: contact_r follows the internal state one cycle after scan end
`include "plc_tc_defines.vh"

module count_unit #(
	parameter W = 16,
	parameter WIDE = 0
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// scan events
	input wire edge_in,
	input wire scan_done,
	input wire power_restore,
	// program control
	input wire dir_down,
	input wire latched,
	input wire rst_cmd,
	input wire load,
	input wire [W-1:0] load_val,
	input wire [W-1:0] setting,
	// state
	output reg [W-1:0] cur_r,
	output reg contact_r
);
	reg state_r;
	wire [W-1:0] up = cur_r + {{(W-1){1'b0}}, 1'b1}; // RULE8 RULE17
	wire [W-1:0] dn = cur_r - {{(W-1){1'b0}}, 1'b1}; // RULE17
	wire [W-1:0] nxt = (WIDE != 0 && dir_down) ? dn : up; // RULE14
	// narrow compares in count order so a negative setting is reached through the wrap
	wire above = (WIDE != 0) ? ($signed(cur_r) > $signed(setting))
		: (cur_r >= setting); // RULE8

	always @(posedge aclk) begin
		if (!aresetn) begin
			cur_r <= {W{1'b0}};
			state_r <= 1'b0;
			contact_r <= 1'b0;
		end else if (power_restore && !latched) begin
			cur_r <= {W{1'b0}}; // RULE11
			state_r <= 1'b0;
			contact_r <= 1'b0;
		end else begin
			if (scan_done)
				contact_r <= state_r; // RULE10
			if (rst_cmd) begin
				cur_r <= {W{1'b0}}; // RULE9
				state_r <= 1'b0; // RULE9
			end else if (load) begin
				cur_r <= load_val;
			end else if (edge_in && (WIDE != 0 || !state_r)) begin // RULE6
				if (above) begin
					cur_r <= setting; // RULE7 RULE12 RULE18
					state_r <= 1'b1;
				end else begin
					cur_r <= nxt; // RULE13
					if (nxt == setting)
						state_r <= (WIDE != 0) ? !dir_down : 1'b1; // RULE6 RULE15
				end
			end
		end
	end
endmodule

// ---- input_contacts.sv ----
// Purpose: input contacts and supply return seen by the counters
// Assumes: levels change just after a rising clock edge
// Notes: a level holds until the bench asks for a change
module input_contacts (
	// clock
	input wire logic aclk,
	// contacts and supply
	output logic narrow_count_in,
	output logic wide_count_in,
	output logic power_restore_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		narrow_count_in = 1'b0;
		wide_count_in = 1'b0;
		power_restore_in = 1'b0;
	end
	task automatic set_in(input bit wide, input logic level);
		@(posedge aclk);
		if (wide)
			wide_count_in <= level;
		else
			narrow_count_in <= level;
	endtask
	// supply drops and returns; held long enough to pass the input filter
	task automatic power_cycle();
		@(posedge aclk);
		power_restore_in <= 1'b1;
		repeat (8) @(posedge aclk);
		power_restore_in <= 1'b0;
	endtask
endmodule

// ---- tc_checker_asserts.sv ----
// Purpose: bus handshake and contact timing checks
// Assumes: one clock, synchronous active low reset
// Notes: contacts move only a few cycles after a bus write or supply return
`include "plc_tc_defines.vh"
module tc_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic power_restore_in,
	input wire logic narrow_contact,
	input wire logic wide_contact
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] quiet_r;
	always @(posedge aclk) begin
		if (!aresetn || s_axi_bvalid || power_restore_in)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	write_reopen_a: assert property (b_done |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
		else $error("write channel not reopened");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {`RESP_OKAY, `RESP_SLVERR})
		else $error("bad write response code");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	contact_scan_a: assert property ($changed(narrow_contact) || $changed(wide_contact) |-> quiet_r <= 4'h6)
		else $error("contact moved outside scan end");
endmodule
bind plc_timers_and_counters tc_checker i_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .power_restore_in(power_restore_in),
	.narrow_contact(narrow_contact), .wide_contact(wide_contact));

// ---- tb_plc_timers_and_counters.sv ----
// Purpose: self-checking bench for the scan-driven timers and counters
// Assumes: tick shortened to 20 cycles, pins settle in about 4 cycles
// Notes: the bench plays the user program over the register bus
`include "plc_tc_defines.vh"
module tb_plc_timers_and_counters;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, ncnt, wcnt, pwr, ncon, wcon;
	logic [`ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp;
	logic [`NUM_TMR-1:0] coil;
	int bad_count, compares;
	plc_timers_and_counters #(.TICK_CYCLES(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .narrow_count_in(ncnt), .wide_count_in(wcnt),
		.power_restore_in(pwr), .timer_coil(coil), .narrow_contact(ncon),
		.wide_contact(wcon));
	input_contacts i_pins (.aclk(aclk), .narrow_count_in(ncnt), .wide_count_in(wcnt),
		.power_restore_in(pwr));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] er = `RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d,
		input logic [1:0] er = `RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		check("rresp", {30'h0, rresp}, {30'h0, er});
	endtask
	task automatic rdchk(input string name, input logic [`ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(name, d, exp);
	endtask
	task automatic scan();
		wr(8'h00, 32'h1);
		repeat (6) @(posedge aclk);
	endtask
	// one off-to-on edge seen by a scan, then back off for a scan
	task automatic pulse(input bit wide);
		i_pins.set_in(wide, 1'b1);
		repeat (6) @(posedge aclk);
		scan();
		i_pins.set_in(wide, 1'b0);
		repeat (6) @(posedge aclk);
		scan();
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		print_verdict();
	end
	initial begin
		aresetn = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk("ncur", 8'h38, 32'h0);
		rd(8'h4c, v, `RESP_SLVERR);
		check("err data", v, 32'h0);
		wr(8'h50, 32'h1, `RESP_SLVERR);
		i_pins.set_in(1'b0, 1'b1);
		repeat (6) @(posedge aclk);
		rdchk("pins", 8'h00, 32'h1);
		i_pins.set_in(1'b0, 1'b0);
		repeat (6) @(posedge aclk);
		// narrow counter counts to its setting and then stops
		wr(8'h34, 32'd3);
		for (int i = 1; i <= 4; i++) begin
			pulse(1'b0);
			rdchk("ncur", 8'h38, (i > 3) ? 32'd3 : 32'(i));
			check("ncon", ncon, i >= 3);
		end
		wr(8'h30, 32'h1);
		rdchk("ncur", 8'h38, 32'h0);
		check("ncon", ncon, 1'b1);
		scan();
		check("ncon", ncon, 1'b0);
		for (int s = 0; s < 2; s++) begin
			wr(8'h34, 32'(s));
			wr(8'h30, 32'h1);
			scan();
			pulse(1'b0);
			check("ncon", ncon, 1'b1);
			rdchk("ncur", 8'h38, 32'(s));
		end
		wr(8'h34, 32'd5);
		wr(8'h30, 32'h1);
		wr(8'h38, 32'd9);
		pulse(1'b0);
		rdchk("ncur", 8'h38, 32'd5);
		check("ncon", ncon, 1'b1);
		// supply return keeps a latched value and clears a plain one
		wr(8'h30, 32'h3);
		pulse(1'b0);
		i_pins.power_cycle();
		repeat (8) @(posedge aclk);
		rdchk("ncur", 8'h38, 32'd1);
		wr(8'h30, 32'h0);
		i_pins.power_cycle();
		repeat (8) @(posedge aclk);
		rdchk("ncur", 8'h38, 32'd0);
		wr(8'h34, 32'h8000);
		wr(8'h38, 32'h7fff);
		pulse(1'b0);
		rdchk("ncur", 8'h38, 32'h8000);
		check("ncon", ncon, 1'b1);
		// wide counter up through the setting, wrap both ways, snap
		wr(8'h44, 32'hffff_fffb);
		wr(8'h40, 32'h1);
		wr(8'h48, 32'hffff_fffa);
		pulse(1'b1);
		rdchk("wcur", 8'h48, 32'hffff_fffb);
		rdchk("wset", 8'h44, 32'hffff_fffb);
		check("wcon", wcon, 1'b1);
		pulse(1'b1);
		rdchk("wcur", 8'h48, 32'hffff_fffc);
		check("wcon", wcon, 1'b1);
		wr(8'h44, 32'h7fff_ffff);
		wr(8'h48, 32'h7fff_ffff);
		pulse(1'b1);
		rdchk("wcur", 8'h48, 32'h8000_0000);
		wr(8'h40, 32'h4);
		pulse(1'b1);
		rdchk("wcur", 8'h48, 32'h7fff_ffff);
		check("wcon", wcon, 1'b0);
		wr(8'h40, 32'h0);
		wr(8'h44, 32'h0);
		wr(8'h48, 32'd5);
		pulse(1'b1);
		rdchk("wcur", 8'h48, 32'h0);
		check("wcon", wcon, 1'b1);
		wr(8'h40, 32'h1);
		rdchk("wcur", 8'h48, 32'h0);
		scan();
		check("wcon", wcon, 1'b0);
		// accumulating timer holds and resumes, general timer clears
		wr(8'h14, 32'd100);
		wr(8'h10, 32'h3);
		repeat (100) @(posedge aclk);
		wr(8'h10, 32'h2);
		rd(8'h18, v);
		check("tmr rate", v >= 32'd4 && v <= 32'd6, 1'b1);
		repeat (60) @(posedge aclk);
		rdchk("tcur", 8'h18, v);
		wr(8'h14, v + 32'd2);
		wr(8'h10, 32'h3);
		repeat (70) @(posedge aclk);
		rdchk("tcur", 8'h18, v + 32'd2);
		check("coil0", coil[0], 1'b1);
		wr(8'h10, 32'h0);
		rdchk("tcur", 8'h18, 32'h0);
		check("coil0", coil[0], 1'b0);
		wr(8'h24, 32'd2);
		wr(8'h20, 32'h5);
		repeat (60) @(posedge aclk);
		rdchk("scur", 8'h28, 32'h0);
		scan();
		rdchk("scur", 8'h28, 32'd2);
		check("coil1", coil[1], 1'b1);
		print_verdict();
	end
endmodule
